// ==== design/sbsram_consts.svh ====
// register offsets, field positions, reset values and counts of the paired burst memory control
`ifndef SBSRAM_CONSTS_SVH
`define SBSRAM_CONSTS_SVH

// register byte offsets on the apb bus
`define OFF_GLOBAL_CTRL 8'h00
`define OFF_SPACE0_CTRL1 8'h04
`define OFF_STATUS 8'h08
`define OFF_GPIO_OUT 8'h0C
`define OFF_ACCESS_ADDR 8'h10
`define OFF_WRITE_DATA 8'h14
`define OFF_COMMAND 8'h18
`define OFF_READ_DATA 8'h1C

// global control fields
`define GC_MEMCLK_EN_BIT 5
`define GC_RESET 32'h0000_0020

// chip-enable space zero control register one
`define CTRL1_MEMORY_TYPE_FIELD_LSB 12
`define CTRL1_MEMORY_TYPE_FIELD_MSB 14
`define CTRL1_TIMING_MSB 11
`define CTRL1_TIMING_RESET 12'hFFF
`define MEMORY_TYPE_FIELD_RESET 3'h2
`define MEMORY_TYPE_FIELD_SBSRAM 3'h4

// status fields
`define ST_READY_BIT 0
`define ST_BUSY_BIT 1
`define ST_ERROR_BIT 2
`define ST_CLKRUN_BIT 3

// general-purpose output line that feeds the memory snooze pin
`define GPIO_LINE7_BIT 7

// command fields
`define CMD_WRITE_BIT 0
`define CMD_BEN_LSB 4
`define CMD_BEN_MSB 7

// timing counts
`define MEM_CLK_DIV 2
`define SNOOZE_LAT_MEMCYC 4
`define READ_WAIT_TICKS 2'h2

`endif

// ==== design/sbsram_lane_split.sv ====
// spreads a 32-bit word and its byte enables over two x18 memories
`timescale 1ns/1ps
`default_nettype none
module sbsram_lane_split #(
   parameter int LANES = 4
) (
   input wire logic [31:0] wordIn,
   input wire logic [3:0] byteEnN,
   input wire sbsram_pkg::half_word_t memAIn,
   input wire sbsram_pkg::half_word_t memBIn,
   output sbsram_pkg::half_word_t memAOut,
   output sbsram_pkg::half_word_t memBOut,
   output logic [1:0] memAByteEnN,
   output logic [1:0] memBByteEnN,
   output logic [31:0] wordOut
);
   // lane layout is fixed by the two-by-two pairing
   if (LANES != 4) begin : g_bad_lanes
      $error("lane split serves exactly four byte lanes");
   end
   logic [35:0] flatOut; // lanes 0,1 on memory a, lanes 2,3 on memory b
   logic [35:0] flatIn;
   assign flatIn = {memBIn, memAIn};
   // each lane: byte in low eight bits, even parity on the ninth
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      assign flatOut[i*9 +: 8] = wordIn[i*8 +: 8];
      assign flatOut[i*9 + 8] = ^wordIn[i*8 +: 8];
      assign wordOut[i*8 +: 8] = flatIn[i*9 +: 8]; // parity ignored on read
   end
   assign memAOut = flatOut[17:0];
   assign memBOut = flatOut[35:18];
   assign memAByteEnN = byteEnN[1:0];
   assign memBByteEnN = byteEnN[3:2];
endmodule : sbsram_lane_split
`default_nettype wire

// ==== design/sbsram_pair_power_down_control.sv ====
// register file and access sequencer for two x18 burst memories with power-down control
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sbsram_consts.svh"
module sbsram_pair_power_down_control #(
   parameter int ADDR_WIDTH = 18
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic memoryClockOut,
   output logic chipEnableSpaceZeroN,
   output logic controllerAddrStrobeN,
   output logic memWriteEnN,
   output logic memOutEnN,
   output logic [ADDR_WIDTH-1:0] memAddr,
   output logic [1:0] memAByteEnN,
   output logic [1:0] memBByteEnN,
   input wire sbsram_pkg::half_word_t memADataIn,
   output sbsram_pkg::half_word_t memADataOut,
   output logic memADataOe,
   input wire sbsram_pkg::half_word_t memBDataIn,
   output sbsram_pkg::half_word_t memBDataOut,
   output logic memBDataOe,
   output logic gpioLineSeven
);
   localparam int LatClks = `SNOOZE_LAT_MEMCYC * `MEM_CLK_DIV; // wake latency in clk cycles
   if (ADDR_WIDTH < 1 || ADDR_WIDTH > 32 || LatClks > 15) begin : g_bad_param
      $error("address width must be 1..32 and latency fit four bits");
   end

   // software-visible state
   logic memClkEn_reg, memClkEn_next;     // memory clock enable bit
   logic [2:0] memory_type_field_reg, memory_type_field_next;     // memory type field
   logic [11:0] timing_reg, timing_next;  // timing fields, stored only
   logic [7:0] gpio_reg, gpio_next;       // general-purpose outputs
   logic [31:0] addr_reg, addr_next;      // access address
   logic [31:0] wdata_reg, wdata_next;    // write data
   logic [31:0] rdata_reg, rdata_next;    // last read word
   logic cmdWrite_reg, cmdWrite_next;     // direction of current access
   logic [3:0] cmdBen_reg, cmdBen_next;   // active-low byte enables
   logic error_reg, error_next;           // sticky refusal flag
   logic [3:0] latCnt_reg, latCnt_next;   // remaining wake latency
   logic [31:0] prdata_reg, prdata_next;  // read data held for access phase
   logic memClk_reg, memClk_next;         // divided memory clock

   // sequencer and pin state
   sbsram_pkg::seq_state_e state_reg, state_next;
   logic [1:0] waitCnt_reg, waitCnt_next;
   logic ceN_reg, ceN_next;
   logic adscN_reg, adscN_next;
   logic weN_reg, weN_next;
   logic oeN_reg, oeN_next;
   logic [3:0] pinBen_reg, pinBen_next;
   logic dataOe_reg, dataOe_next;
   sbsram_pkg::half_word_t outA_reg, outA_next;
   sbsram_pkg::half_word_t outB_reg, outB_next;

   // decode and handshakes
   logic apbWrite;     // write taken this cycle
   logic apbSetup;     // setup phase, read data is fetched now
   logic addrMapped;
   logic tick;         // edge at which the memory clock falls
   logic memReady;     // memory may be accessed
   logic busy;
   logic startAccept;  // command accepted this cycle
   logic [31:0] readWord;
   logic [31:0] statusWord;
   sbsram_pkg::half_word_t syncA, syncB, splitA, splitB;
   logic [1:0] splitBenA, splitBenB;

   assign pready = 1'b1; // zero wait states: every access completes in its first access cycle
   assign apbSetup = psel && !penable;
   assign apbWrite = psel && penable && pwrite && addrMapped;
   assign addrMapped = (paddr[1:0] == 2'h0) && (paddr <= `OFF_READ_DATA);
   assign pslverr = psel && penable && !addrMapped;
   assign tick = memClkEn_reg && memClk_reg;
   assign busy = (state_reg != sbsram_pkg::S_IDLE);
   // ready only with snooze released, clock on and latency spent
   assign memReady = memClkEn_reg && !gpio_reg[`GPIO_LINE7_BIT] && (latCnt_reg == 4'h0);
   assign statusWord = {28'h0000000, memClkEn_reg, error_reg, busy, memReady};

   // read data pins pass two flops before anything looks at them
   sbsram_sync2 #(.WIDTH(18)) u_sync_a (
      .clk(clk), .sys_rst(sys_rst), .asyncIn(memADataIn), .syncOut(syncA)
   );
   sbsram_sync2 #(.WIDTH(18)) u_sync_b (
      .clk(clk), .sys_rst(sys_rst), .asyncIn(memBDataIn), .syncOut(syncB)
   );

   // word split across the pair, each memory carrying two lanes
   sbsram_lane_split #(.LANES(4)) u_split (
      .wordIn(wdata_reg),
      .byteEnN(cmdBen_reg),
      .memAIn(syncA),
      .memBIn(syncB),
      .memAOut(splitA),
      .memBOut(splitB),
      .memAByteEnN(splitBenA),
      .memBByteEnN(splitBenB),
      .wordOut(readWord)
   );

   // register file, clock divider and latency counter
   always_comb begin
      memClkEn_next = memClkEn_reg;
      memory_type_field_next = memory_type_field_reg;
      timing_next = timing_reg;
      gpio_next = gpio_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      cmdWrite_next = cmdWrite_reg;
      cmdBen_next = cmdBen_reg;
      error_next = error_reg;
      prdata_next = prdata_reg;
      startAccept = 1'b0;
      latCnt_next = (latCnt_reg != 4'h0) ? latCnt_reg - 4'h1 : 4'h0;
      // divider holds low while gated, so the pin rests low
      memClk_next = memClkEn_reg ? !memClk_reg : 1'b0;
      if (apbWrite) begin
         case (paddr)
            `OFF_GLOBAL_CTRL: begin
               memClkEn_next = pwdata[`GC_MEMCLK_EN_BIT];
               // restarting the clock costs the wake latency
               if (pwdata[`GC_MEMCLK_EN_BIT] && !memClkEn_reg) begin
                  latCnt_next = 4'(LatClks);
               end
            end
            `OFF_SPACE0_CTRL1: begin
               memory_type_field_next = pwdata[`CTRL1_MEMORY_TYPE_FIELD_MSB:`CTRL1_MEMORY_TYPE_FIELD_LSB];
               timing_next = pwdata[`CTRL1_TIMING_MSB:0];
            end
            `OFF_STATUS: begin
               // write one clears the error flag
               if (pwdata[`ST_ERROR_BIT]) begin
                  error_next = 1'b0;
               end
            end
            `OFF_GPIO_OUT: begin
               // snooze may not change under a running access
               if (busy) begin
                  error_next = 1'b1;
               end else begin
                  gpio_next = pwdata[7:0];
                  if (pwdata[`GPIO_LINE7_BIT] != gpio_reg[`GPIO_LINE7_BIT]) begin
                     latCnt_next = 4'(LatClks);
                  end
               end
            end
            `OFF_ACCESS_ADDR: addr_next = pwdata;
            `OFF_WRITE_DATA: wdata_next = pwdata;
            `OFF_COMMAND: begin
               // only the burst type, idle and ready memory take a command
               if (!busy && memReady && memory_type_field_reg == `MEMORY_TYPE_FIELD_SBSRAM) begin
                  startAccept = 1'b1;
                  cmdWrite_next = pwdata[`CMD_WRITE_BIT];
                  cmdBen_next = pwdata[`CMD_WRITE_BIT] ? pwdata[`CMD_BEN_MSB:`CMD_BEN_LSB]
                                                       : 4'h0;
               end else begin
                  error_next = 1'b1;
               end
            end
            default: begin
               // read-only offsets ignore writes
            end
         endcase
      end
      // read capture from the sequencer
      if (state_reg == sbsram_pkg::S_RWAIT && tick && waitCnt_reg == 2'h1) begin
         rdata_next = readWord;
      end else begin
         rdata_next = rdata_reg;
      end
      // read mux sampled in setup, held through the access phase
      if (apbSetup) begin
         case (paddr)
            `OFF_GLOBAL_CTRL: prdata_next = 32'(memClkEn_reg) << `GC_MEMCLK_EN_BIT;
            `OFF_SPACE0_CTRL1: prdata_next = {17'h00000, memory_type_field_reg, timing_reg};
            `OFF_STATUS: prdata_next = statusWord;
            `OFF_GPIO_OUT: prdata_next = {24'h000000, gpio_reg};
            `OFF_ACCESS_ADDR: prdata_next = addr_reg;
            `OFF_WRITE_DATA: prdata_next = wdata_reg;
            `OFF_COMMAND: prdata_next = {24'h000000, cmdBen_reg, 3'h0, cmdWrite_reg};
            `OFF_READ_DATA: prdata_next = rdata_reg;
            default: prdata_next = 32'h0000_0000;
         endcase
      end
   end

   // register file flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         memClkEn_reg <= 1'(`GC_RESET >> `GC_MEMCLK_EN_BIT);
         memory_type_field_reg <= `MEMORY_TYPE_FIELD_RESET;
         timing_reg <= `CTRL1_TIMING_RESET;
         gpio_reg <= 8'h00;
         addr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         rdata_reg <= 32'h0000_0000;
         cmdWrite_reg <= 1'b0;
         cmdBen_reg <= 4'hF;
         error_reg <= 1'b0;
         latCnt_reg <= 4'h0;
         prdata_reg <= 32'h0000_0000;
         memClk_reg <= 1'b0;
      end else begin
         memClkEn_reg <= memClkEn_next;
         memory_type_field_reg <= memory_type_field_next;
         timing_reg <= timing_next;
         gpio_reg <= gpio_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         cmdWrite_reg <= cmdWrite_next;
         cmdBen_reg <= cmdBen_next;
         error_reg <= error_next;
         latCnt_reg <= latCnt_next;
         prdata_reg <= prdata_next;
         memClk_reg <= memClk_next;
      end
   end

   // access sequencer; pins change only at memory clock falls
   always_comb begin
      state_next = state_reg;
      waitCnt_next = waitCnt_reg;
      ceN_next = ceN_reg;
      adscN_next = adscN_reg;
      weN_next = weN_reg;
      oeN_next = oeN_reg;
      pinBen_next = pinBen_reg;
      dataOe_next = dataOe_reg;
      outA_next = outA_reg;
      outB_next = outB_reg;
      case (state_reg)
         sbsram_pkg::S_IDLE: begin
            // idle: select and strobe stay inactive for low power
            ceN_next = 1'b1;
            adscN_next = 1'b1;
            if (startAccept) begin
               state_next = sbsram_pkg::S_LAUNCH;
            end
         end
         sbsram_pkg::S_LAUNCH: begin
            // a stopped clock freezes the sequencer here
            if (tick) begin
               ceN_next = 1'b0;
               adscN_next = 1'b0;
               weN_next = !cmdWrite_reg;
               oeN_next = cmdWrite_reg;
               pinBen_next = {splitBenB, splitBenA};
               outA_next = splitA;
               outB_next = splitB;
               dataOe_next = cmdWrite_reg;
               state_next = sbsram_pkg::S_ACTIVE;
            end
         end
         sbsram_pkg::S_ACTIVE: begin
            if (tick) begin
               ceN_next = 1'b1;
               adscN_next = 1'b1;
               weN_next = 1'b1;
               dataOe_next = 1'b0;
               pinBen_next = 4'hF;
               waitCnt_next = `READ_WAIT_TICKS;
               state_next = cmdWrite_reg ? sbsram_pkg::S_IDLE : sbsram_pkg::S_RWAIT;
            end
         end
         sbsram_pkg::S_RWAIT: begin
            // pipeline plus synchroniser delay before the word is good
            if (tick) begin
               waitCnt_next = waitCnt_reg - 2'h1;
               if (waitCnt_reg == 2'h1) begin
                  oeN_next = 1'b1;
                  state_next = sbsram_pkg::S_IDLE;
               end
            end
         end
         default: begin
            state_next = sbsram_pkg::S_IDLE;
         end
      endcase
   end

   // sequencer flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= sbsram_pkg::S_IDLE;
         waitCnt_reg <= 2'h0;
         ceN_reg <= 1'b1;
         adscN_reg <= 1'b1;
         weN_reg <= 1'b1;
         oeN_reg <= 1'b1;
         pinBen_reg <= 4'hF;
         dataOe_reg <= 1'b0;
         outA_reg <= 18'h00000;
         outB_reg <= 18'h00000;
      end else begin
         state_reg <= state_next;
         waitCnt_reg <= waitCnt_next;
         ceN_reg <= ceN_next;
         adscN_reg <= adscN_next;
         weN_reg <= weN_next;
         oeN_reg <= oeN_next;
         pinBen_reg <= pinBen_next;
         dataOe_reg <= dataOe_next;
         outA_reg <= outA_next;
         outB_reg <= outB_next;
      end
   end

   assign prdata = prdata_reg;
   assign memoryClockOut = memClk_reg;
   assign chipEnableSpaceZeroN = ceN_reg;
   assign controllerAddrStrobeN = adscN_reg;
   assign memWriteEnN = weN_reg;
   assign memOutEnN = oeN_reg;
   assign memAddr = addr_reg[ADDR_WIDTH-1:0];
   assign memAByteEnN = pinBen_reg[1:0];
   assign memBByteEnN = pinBen_reg[3:2];
   assign memADataOut = outA_reg;
   assign memBDataOut = outB_reg;
   assign memADataOe = dataOe_reg;
   assign memBDataOe = dataOe_reg;
   assign gpioLineSeven = gpio_reg[`GPIO_LINE7_BIT];

   // checks on the pins this block drives and on its refusal and ready logic
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic memClkEnReg; // copy of the enable bit for the checks
   assign memClkEnReg = memClkEn_reg;
   sequence readLaunch;
      $fell(memOutEnN);
   endsequence
   sequence clockRestart;
      $rose(memClkEnReg);
   endsequence

   a_idle_pins_off: assert property (state_reg == sbsram_pkg::S_IDLE |-> chipEnableSpaceZeroN && controllerAddrStrobeN)
      else $error("select or strobe active while idle");
   a_no_access_snooze: assert property (!chipEnableSpaceZeroN |-> !gpioLineSeven && memClkEnReg)
      else $error("access while snoozed or clock stopped");
   a_clock_stops: assert property (!memClkEnReg [*2] |-> !memoryClockOut)
      else $error("memory clock runs while disabled");
   a_clock_toggles: assert property (memClkEnReg && memoryClockOut |=> !memoryClockOut)
      else $error("memory clock stuck high while enabled");
   a_wake_latency: assert property (clockRestart |-> chipEnableSpaceZeroN [*8])
      else $error("access within wake latency after clock restart");
   a_snooze_latency: assert property ($changed(gpioLineSeven) |-> !memReady [*8])
      else $error("ready within snooze latency");
   a_lane_split: assert property ($rose(memADataOe) |-> memADataOut[7:0] == wdata_reg[7:0] && memBDataOut[7:0] == wdata_reg[23:16] && memBDataOut[17] == ^wdata_reg[31:24])
      else $error("write word not split over both memories");
   a_byte_enables: assert property (!chipEnableSpaceZeroN && !memWriteEnN |-> {memBByteEnN, memAByteEnN} == cmdBen_reg)
      else $error("byte enables not spread over the pair");
   a_refuse_type: assert property (apbWrite && paddr == `OFF_COMMAND && memory_type_field_reg != `MEMORY_TYPE_FIELD_SBSRAM |=> error_reg && state_reg == sbsram_pkg::S_IDLE)
      else $error("command taken without burst memory type");
   a_read_timing: assert property (readLaunch ##1 memClkEnReg [*6] |-> memOutEnN && $past(!memOutEnN))
      else $error("read pipeline length wrong");
endmodule : sbsram_pair_power_down_control
`default_nettype wire

// ==== design/sbsram_pkg.sv ====
// types shared by the paired burst memory control
package sbsram_pkg;
   // memory sequencer states, one-hot
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_LAUNCH = 4'b0010,
      S_ACTIVE = 4'b0100,
      S_RWAIT = 4'b1000
   } seq_state_e;
   // one memory's pin group: two bytes plus their parity
   typedef logic [17:0] half_word_t;
endpackage : sbsram_pkg

// ==== design/sbsram_sync2.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sbsram_sync2 #(
   parameter int WIDTH = 18
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   if (WIDTH < 1) begin : g_bad_width
      $error("sync width must be positive");
   end
   logic [WIDTH-1:0] stage1_reg; // first stage, read only by stage two
   logic [WIDTH-1:0] stage2_reg; // settled copy
   // both stages clear on reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end
   assign syncOut = stage2_reg;
endmodule : sbsram_sync2
`default_nettype wire

// ==== testbench/sbsram_pair_model.sv ====
// behavioural pair of x18 pipelined burst memories behind the controller
`timescale 1ns/1ps
`default_nettype none
module sbsram_pair_model (
   input wire logic memClk,
   input wire logic ceN,
   input wire logic adscN,
   input wire logic weN,
   input wire logic [17:0] addr,
   input wire logic [1:0] aBenN,
   input wire logic [1:0] bBenN,
   input wire sbsram_pkg::half_word_t aPin,
   input wire sbsram_pkg::half_word_t bPin,
   input wire logic snooze,
   output sbsram_pkg::half_word_t aDrv,
   output sbsram_pkg::half_word_t bDrv
);
   sbsram_pkg::half_word_t memA [0:63]; // small slice of each array
   sbsram_pkg::half_word_t memB [0:63];
   sbsram_pkg::half_word_t lastA = 18'h00000; // last value put on the lines
   sbsram_pkg::half_word_t lastB = 18'h00000;
   logic [5:0] rdAddr = 6'h00;
   logic [2:0] pipe = 3'h0; // read pipeline
   int wake = 4; // memory clocks since snooze fell
   wire logic drv = pipe[1] | pipe[2]; // data after the second rise, held two periods
   // released lines show the inverse of the last value, never a stale copy
   assign aDrv = drv ? memA[rdAddr] : ~lastA;
   assign bDrv = drv ? memB[rdAddr] : ~lastB;
   // a stopped memory clock freezes everything here except the clear on a rising snooze
   always @(posedge memClk or posedge snooze) begin
      if (snooze) begin
         wake <= 0;
         pipe <= 3'h0;
      end else if (wake < 4) begin
         wake <= wake + 1;
         pipe <= 3'h0;
      end else begin
         pipe <= {pipe[1:0], ~ceN & ~adscN & weN};
         if (drv) begin
            lastA <= memA[rdAddr];
            lastB <= memB[rdAddr];
         end
         if (!ceN && !adscN && weN) rdAddr <= addr[5:0];
         if (!ceN && !adscN && !weN) begin // byte lanes written one by one
            if (!aBenN[0]) memA[addr[5:0]][8:0] <= aPin[8:0];
            if (!aBenN[1]) memA[addr[5:0]][17:9] <= aPin[17:9];
            if (!bBenN[0]) memB[addr[5:0]][8:0] <= bPin[8:0];
            if (!bBenN[1]) memB[addr[5:0]][17:9] <= bPin[17:9];
         end
      end
   end
endmodule : sbsram_pair_model
`default_nettype wire

// ==== testbench/tb_sbsram_pair_power_down_control.sv ====
// self-checking bench: apb register traffic driving the paired memories
`timescale 1ns/1ps
`default_nettype none
`include "sbsram_consts.svh"
module tb_sbsram_pair_power_down_control;
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, memClk, ceN, adscN, weN, oeN, aOe, bOe, snooze;
   logic [17:0] memAddr;
   logic [1:0] aBenN, bBenN;
   sbsram_pkg::half_word_t aOut, bOut, aDrv, bDrv, aPin, bPin;
   logic [31:0] rdq; // data of the last transfer
   logic errq; // error flag of the last transfer
   int nMismatch = 0;
   int totalChecks = 0;
   int cycles = 0;
   // resolved data lines: whoever enables drives
   assign aPin = aOe ? aOut : aDrv;
   assign bPin = bOe ? bOut : bDrv;
   always #25 clk = ~clk;
   sbsram_pair_power_down_control i_sbsram_pair_power_down_control (
      .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .memoryClockOut(memClk), .chipEnableSpaceZeroN(ceN),
      .controllerAddrStrobeN(adscN), .memWriteEnN(weN), .memOutEnN(oeN),
      .memAddr(memAddr), .memAByteEnN(aBenN), .memBByteEnN(bBenN),
      .memADataIn(aPin), .memADataOut(aOut), .memADataOe(aOe),
      .memBDataIn(bPin), .memBDataOut(bOut), .memBDataOe(bOe), .gpioLineSeven(snooze));
   sbsram_pair_model i_sbsram_pair_model (
      .memClk(memClk), .ceN(ceN), .adscN(adscN), .weN(weN), .addr(memAddr),
      .aBenN(aBenN), .bBenN(bBenN), .aPin(aPin), .bPin(bPin), .snooze(snooze),
      .aDrv(aDrv), .bDrv(bDrv));
   // verdict and end of run, also reached by the hang guard
   task wrap_up;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   // compare one value
   task chk(input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("ERROR at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk
   // one apb transfer; request held until pready is seen high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdq = prdata;
      errq = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // read and compare under a mask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      apb(1'b0, a, 32'h00000000);
      chk(exp, rdq & mask);
   endtask : rd_chk
   // poll status until the masked bits match, bounded
   task poll(input logic [31:0] mask, input logic [31:0] val);
      for (int k = 0; k < 40; k++) begin
         apb(1'b0, `OFF_STATUS, 32'h00000000);
         if ((rdq & mask) === val) break;
      end
      chk(val, rdq & mask);
   endtask : poll
   // launch a memory access and wait for busy to drop
   task mem_op(input logic [31:0] cmd);
      apb(1'b1, `OFF_COMMAND, cmd);
      poll(32'h00000002, 32'h00000000);
   endtask : mem_op
   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         nMismatch++;
         wrap_up;
      end
   end
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      sysRst <= 1'b0;
      rd_chk(`OFF_GLOBAL_CTRL, 32'h00000020, 32'hFFFFFFFF);
      rd_chk(`OFF_SPACE0_CTRL1, 32'h00002FFF, 32'hFFFFFFFF);
      rd_chk(`OFF_STATUS, 32'h00000009, 32'h0000000F);
      apb(1'b0, 8'h20, 32'h00000000);
      chk(32'h00000001, {31'h0, errq});
      chk(32'h00000003, {30'h0, ceN, adscN});
      // access with the reset memory type must be refused
      apb(1'b1, `OFF_COMMAND, 32'h00000001);
      rd_chk(`OFF_STATUS, 32'h0000000D, 32'h0000000F);
      apb(1'b1, `OFF_STATUS, 32'h00000004);
      apb(1'b1, `OFF_SPACE0_CTRL1, 32'h00004FFF);
      rd_chk(`OFF_SPACE0_CTRL1, 32'h00004FFF, 32'hFFFFFFFF);
      // full word, then a partial write over lanes 0 and 2 only
      apb(1'b1, `OFF_ACCESS_ADDR, 32'h00000005);
      apb(1'b1, `OFF_WRITE_DATA, 32'h12345678);
      mem_op(32'h00000001);
      apb(1'b1, `OFF_WRITE_DATA, 32'hAABBCCDD);
      mem_op(32'h000000A1);
      chk(32'h00000003, {30'h0, ceN, adscN});
      mem_op(32'h00000000);
      rd_chk(`OFF_READ_DATA, 32'h12BB56DD, 32'hFFFFFFFF);
      // snooze through the general-purpose line; accesses refused meanwhile
      apb(1'b1, `OFF_GPIO_OUT, 32'h00000080);
      @(negedge clk); // let the line settle after the write edge
      chk(32'h00000001, {31'h0, snooze});
      rd_chk(`OFF_STATUS, 32'h00000008, 32'h0000000F);
      apb(1'b1, `OFF_COMMAND, 32'h00000000);
      rd_chk(`OFF_STATUS, 32'h0000000C, 32'h0000000F);
      apb(1'b1, `OFF_STATUS, 32'h00000004);
      apb(1'b1, `OFF_GPIO_OUT, 32'h00000000);
      poll(32'h00000001, 32'h00000001);
      mem_op(32'h00000000);
      rd_chk(`OFF_READ_DATA, 32'h12BB56DD, 32'hFFFFFFFF);
      // stop the memory clock, then bring it back
      apb(1'b1, `OFF_GLOBAL_CTRL, 32'h00000000);
      repeat (2) @(posedge clk);
      repeat (4) begin
         @(posedge clk);
         chk(32'h00000000, {31'h0, memClk});
      end
      rd_chk(`OFF_STATUS, 32'h00000000, 32'h00000009);
      apb(1'b1, `OFF_GLOBAL_CTRL, 32'h00000020);
      poll(32'h00000001, 32'h00000001);
      mem_op(32'h00000000);
      rd_chk(`OFF_READ_DATA, 32'h12BB56DD, 32'hFFFFFFFF);
      wrap_up;
   end
endmodule : tb_sbsram_pair_power_down_control
`default_nettype wire
